// *** verification/updown_reload_timer_8bit_tb_top.sv ***
// Random bench for the up/down reload timer.
// Assumes the far-side model and checker are compiled first.
module updown_reload_timer_8bit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n = 1'b0, hwrite = 1'b0, go = 1'b0, dirv = 1'b0, slow = 1'b0, sub = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [5:0] tick = 6'h00, pwr = 6'h01;
    logic [7:0] n = 8'h01, cnt;
    logic hrdy, hresp, irq, evt, subq, dirp, busy, elv = 1'b0, slv = 1'b0;
    int seed = 32'h3A17, n_fail = 0, checked = 0;
    updown_reload_timer_8bit dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(1'b1), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(utmr_pkg::HSIZE_WORD), .HWDATA_I(hwdata),
        .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp), .PRESCALE_TICK_I(tick),
        .SUBCLK_QTR_I(subq), .EVENT_I(evt), .COUNT_DIR_I(dirp), .POWER_MODE_I(pwr), .IRQ_O(irq), .COUNT_O(cnt));
    utmr_far far (.clk_i(clk), .go_i(go), .n_i(n), .sub_i(sub), .slow_i(slow), .dir_i(dirv), .evt_o(evt),
        .subq_o(subq), .dir_o(dirp), .busy_o(busy));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic tally_and_finish(input int to);
        n_fail += to;
        if (n_fail == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Bounded wait for bus ready (b=1) or for the far side to go idle
    task automatic wt(input logic b);
        int k;
        k = 0;
        @(posedge clk);
        while ((b ? hrdy : !busy) !== 1'b1)
        begin
            k++;
            if (k > 5000)
                tally_and_finish(1);
            @(posedge clk);
        end
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] x, input logic [7:0] d, output logic [31:0] q);
        haddr <= {14'h0, x, 2'h0};
        htrans <= utmr_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        wt(1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wt(1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [15:0] x, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, x, d, q);
    endtask
    task automatic rd(input logic [15:0] x, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, x, 8'h00, q);
        cmp(q, e);
        cmp({31'h0, hresp}, 32'h0);
    endtask
    // Returns {wrap seen, final count} after k steps of size st
    function automatic logic [8:0] step(input logic [7:0] v, input int k, input logic dn, ar,
        input logic [7:0] rl, input logic [1:0] st);
        logic [8:0] s;
        logic f;
        f = 1'b0;
        repeat (k)
        begin
            s = dn ? {1'b0, v} - st : {1'b0, v} + st;
            f |= s[8];
            v = (s[8] && ar) ? rl : s[7:0];
        end
        return {f, v};
    endfunction
    initial
    begin
        logic [31:0] r;
        logic [7:0] md, rl, ax;
        logic [8:0] e;
        logic [5:0] pw;
        logic dn, run;
        int ne;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        wt(1'b1);
        rd(utmr_pkg::MODE_IDX, {24'h0, utmr_pkg::MODE_RESET});
        rd(utmr_pkg::COUNT_IDX, 32'h0);
        rd(16'hFFB7, 32'h0);
        for (int i = 0; i < 24; i++)
        begin
            r = $random(seed);
            md = {r[7:3], 3'(i)};
            rl = r[15:8];
            n = r[23:16] | 8'h01;
            ax = {4'h0, r[27:25], 1'b0};
            pw = 6'h01 << (r[30:28] % 3'h6);
            if (i < 2)
            begin
                md = i[0] ? 8'h3D : 8'h9D;
                rl = i[0] ? 8'h00 : 8'hFF;
                pw = 6'h01;
            end
            pwr <= pw;
            dirv <= r[31];
            wr(utmr_pkg::MODE_IDX, md);
            rd(utmr_pkg::MODE_IDX, {24'h0, md | utmr_pkg::MODE_FIXED_ONES});
            wr(utmr_pkg::AUX_IDX, ax);
            wr(utmr_pkg::COUNT_IDX, rl);
            rd(utmr_pkg::COUNT_IDX, {24'h0, rl});
            if (md[2:1] != 2'b11)
            begin
                repeat (n)
                begin
                    tick <= 6'h01 << md[2:0];
                    @(posedge clk);
                    tick <= ~(6'h01 << md[2:0]);
                    @(posedge clk);
                end
                ne = n;
            end
            else
            begin
                sub = !md[0];
                slow = r[4];
                go <= 1'b1;
                @(posedge clk);
                go <= 1'b0;
                wt(1'b0);
                ne = (md[0] ? elv : slv) ? n / 2 : (n + 1) / 2;
                if (md[0] && ax[2])
                    ne = n - ne;
                if (md[0])
                    elv ^= n[0];
                else
                    slv ^= n[0];
            end
            tick <= 6'h00;
            repeat (6) @(posedge clk);
            run = pw[0] | pw[1] | ((pw[4] | pw[5]) & md[2] & md[1]);
            dn = md[6] ? r[31] : md[5];
            e = step(rl, run ? ne : 0, dn, md[7], rl, (ax[3] && md[2:0] == 3'h6 && (pw[4] | pw[5])) ? 2'h2 : 2'h1);
            rd(utmr_pkg::COUNT_IDX, {24'h0, e[7:0]});
            rd(utmr_pkg::AUX_IDX, {28'h0, ax[3:1], e[8]});
            cmp({31'h0, irq}, {31'h0, e[8] & ax[1]});
        end
        tally_and_finish(0);
    end
endmodule
bind updown_reload_timer_8bit utmr_chk chk (.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .HSEL_I(HSEL_I),
    .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .POWER_MODE_I(POWER_MODE_I), .IRQ_O(IRQ_O), .COUNT_O(COUNT_O));

// *** verification/utmr_chk.sv ***
// Checker on the timer's top ports.
// Assumes HREADY_I is looped back from HREADYOUT_O.
module utmr_chk (
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    input wire logic [5:0] POWER_MODE_I,
    input wire logic IRQ_O,
    input wire logic [7:0] COUNT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    logic acc, rda, wr_q, rdm_q, rdc_q, halt;
    assign acc = HSEL_I && HREADY_I && HTRANS_I == utmr_pkg::HTRANS_NONSEQ;
    assign rda = acc && !HWRITE_I;
    assign halt = POWER_MODE_I inside {6'h04, 6'h08};
    // Data-phase markers: a write lands, or a read returns, at the next edge
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            {wr_q, rdm_q, rdc_q} <= 3'h0;
        else
            {wr_q, rdm_q, rdc_q} <= {acc && HWRITE_I, rda && HADDR_I[17:2] == utmr_pkg::MODE_IDX,
                rda && HADDR_I[17:2] == utmr_pkg::COUNT_IDX};
    end
    property p_halt;
        halt ##1 (halt && !$past(wr_q)) |-> $stable(COUNT_O);
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved while halted");
    property p_irq_rise;
        $rose(IRQ_O) && !$past(wr_q, 2) |-> $past(COUNT_O, 2) inside {8'h00, 8'h01, 8'hFE, 8'hFF};
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq without wrap");
    property p_irq_fall;
        $fell(IRQ_O) |-> $past(wr_q, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
    property p_cnt_rd;
        rdc_q |-> HRDATA_O == {24'h0, $past(COUNT_O)};
    endproperty
    a_cnt_rd: assert property (p_cnt_rd) else $error("count read wrong");
    property p_mode_rd;
        rdm_q |-> HRDATA_O[31:8] == 24'h0 && HRDATA_O[4:3] == 2'h3;
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode fixed bits wrong");
    property p_rdy_keep;
        HREADYOUT_O |=> HREADYOUT_O;
    endproperty
    a_rdy_keep: assert property (p_rdy_keep) else $error("wait state seen");
    property p_rdy_start;
        $rose(RESET_N_I) |-> ##[0:4] HREADYOUT_O;
    endproperty
    a_rdy_start: assert property (p_rdy_start) else $error("ready late after reset");
    property p_rst_val;
        $rose(RESET_N_I) |-> (COUNT_O == utmr_pkg::COUNT_RESET && !IRQ_O)[*2];
    endproperty
    a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
    c_irq: cover property ($rose(IRQ_O));
    c_halt_wr: cover property (halt && wr_q);
    c_cnt_rd: cover property (rdc_q);
endmodule

// *** verification/utmr_far.sv ***
// Far side: event line, subclock-quarter line and direction pin.
// Assumes go_i lasts one cycle and n_i, sub_i are steady by then.
module utmr_far (
    input wire logic clk_i, // Clock
    input wire logic go_i, // Start burst
    input wire logic [7:0] n_i, // Toggles
    input wire logic sub_i, // Use subclock line
    input wire logic slow_i, // Long half period
    input wire logic dir_i, // Wanted direction
    output logic evt_o, // Event line
    output logic subq_o, // Subclock line
    output logic dir_o, // Direction pin
    output logic busy_o // Burst running
);
    timeunit 1ns;
    timeprecision 1ps;
    assign dir_o = dir_i;
    initial
    begin
        evt_o = 1'b0;
        subq_o = 1'b0;
        busy_o = 1'b0;
    end
    always @(posedge clk_i)
    begin
        if (go_i)
        begin
            busy_o <= 1'b1;
            repeat (n_i)
            begin
                repeat (slow_i ? 9 : 4) @(posedge clk_i);
                if (sub_i)
                    subq_o <= !subq_o;
                else
                    evt_o <= !evt_o;
            end
            busy_o <= 1'b0;
        end
    end
endmodule

// *** verilog/updown_reload_timer_8bit.sv ***
// 8-bit up/down interval and auto-reload timer with an AHB-Lite slave.
// Assumes prescaler ticks are one-cycle pulses on the system clock;
// subclock-quarter, event and direction inputs may be asynchronous.
module updown_reload_timer_8bit #(
    parameter int N_PRESCALE = 6
) (
    input wire logic SYS_CLK_I, // System clock, 250 MHz
    input wire logic RESET_N_I, // Asynchronous reset, active low
    input wire logic HSEL_I, // Slave select
    input wire logic [31:0] HADDR_I, // Byte address
    input wire logic [1:0] HTRANS_I, // Transfer type
    input wire logic HWRITE_I, // Write when high
    input wire logic [2:0] HSIZE_I, // Transfer size
    input wire logic [31:0] HWDATA_I, // Write data
    input wire logic HREADY_I, // Bus ready
    output logic [31:0] HRDATA_O, // Read data
    output logic HREADYOUT_O, // Slave ready
    output logic HRESP_O, // Always OKAY
    input wire logic [N_PRESCALE-1:0] PRESCALE_TICK_I, // /8192../4 ticks
    input wire logic SUBCLK_QTR_I, // Subclock-quarter clock level
    input wire logic EVENT_I, // External event input
    input wire logic COUNT_DIR_I, // Direction input, high counts down
    input wire logic [5:0] POWER_MODE_I, // One-hot power state
    output logic IRQ_O, // Interrupt request to CPU
    output logic [7:0] COUNT_O // Live counter value
);
    // Elaboration-time check: only the six documented prescaler taps are decoded
    if (N_PRESCALE != 6)
    begin : g_bad_prescale
        $error("N_PRESCALE must be 6");
    end

    logic rst_meta_q, rst_n;
    logic ev_meta_q, ev_sync_q, ev_prev_q;
    logic dir_meta_q, dir_sync_q;
    logic sq_meta_q, sq_sync_q, sq_prev_q;
    logic [7:0] mode_q, count_q, reload_q;
    logic [3:0] aux_q;
    utmr_pkg::bus_req_s req_q;
    logic [31:0] rdata_q;
    logic ready_q, irq_q;

    // Reset release through two flops
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Input synchronisers, edge detectors look at the second stage only
    always_ff @(posedge SYS_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ev_meta_q <= 1'b0;
            ev_sync_q <= 1'b0;
            ev_prev_q <= 1'b0;
            dir_meta_q <= 1'b0;
            dir_sync_q <= 1'b0;
            sq_meta_q <= 1'b0;
            sq_sync_q <= 1'b0;
            sq_prev_q <= 1'b0;
        end
        else
        begin
            ev_meta_q <= EVENT_I;
            ev_sync_q <= ev_meta_q;
            ev_prev_q <= ev_sync_q;
            dir_meta_q <= COUNT_DIR_I;
            dir_sync_q <= dir_meta_q;
            sq_meta_q <= SUBCLK_QTR_I;
            sq_sync_q <= sq_meta_q;
            sq_prev_q <= sq_sync_q;
        end
    end

    // Bus decode
    logic [15:0] addr_idx;
    logic addr_ok;
    logic take;
    logic wr_mode, wr_reload, wr_aux;

    assign addr_idx = HADDR_I[17:2];
    assign addr_ok = (HADDR_I[31:18] == 14'h0000) && (HADDR_I[1:0] == 2'h0);
    assign take = HSEL_I && HREADY_I && (HTRANS_I == utmr_pkg::HTRANS_NONSEQ)
        && (HSIZE_I == utmr_pkg::HSIZE_WORD) && addr_ok;
    assign wr_mode = req_q.valid && req_q.write && (req_q.idx == utmr_pkg::MODE_IDX);
    assign wr_reload = req_q.valid && req_q.write && (req_q.idx == utmr_pkg::COUNT_IDX);
    assign wr_aux = req_q.valid && req_q.write && (req_q.idx == utmr_pkg::AUX_IDX);

    // Read data taken at the address phase, valid in the data phase
    logic [31:0] rdata_d;
    always_comb
    begin
        rdata_d = 32'h00000000;
        if (take && !HWRITE_I)
        begin
            case (addr_idx)
                utmr_pkg::MODE_IDX: rdata_d = {24'h000000, mode_q | utmr_pkg::MODE_FIXED_ONES};
                utmr_pkg::COUNT_IDX: rdata_d = {24'h000000, count_q};
                utmr_pkg::AUX_IDX: rdata_d = {28'h0000000, aux_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_q <= '0;
            rdata_q <= 32'h00000000;
            ready_q <= 1'b0;
        end
        else
        begin
            ready_q <= 1'b1;
            if (HREADY_I)
            begin
                req_q.valid <= take;
                req_q.write <= HWRITE_I;
                req_q.idx <= addr_idx;
                rdata_q <= rdata_d;
            end
        end
    end

    // Mode register; reserved bits stay one
    always_ff @(posedge SYS_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= utmr_pkg::MODE_RESET;
        end
        else if (wr_mode)
        begin
            mode_q <= (HWDATA_I[7:0] & utmr_pkg::MODE_WR_MASK) | utmr_pkg::MODE_FIXED_ONES;
        end
    end

    // Reload register, write-only at the shared address
    always_ff @(posedge SYS_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reload_q <= utmr_pkg::RELOAD_RESET;
        end
        else if (wr_reload)
        begin
            reload_q <= HWDATA_I[7:0];
        end
    end

    // Count source and gating
    logic [2:0] clk_sel;
    logic ev_edge, sq_edge, src_tick, run, sub_mode, dir_down, tick;
    logic [7:0] step;

    assign clk_sel = mode_q[utmr_pkg::CLK_SEL_LSB+:3];
    assign ev_edge = aux_q[utmr_pkg::AUX_EDGE_POS] ? (ev_prev_q && !ev_sync_q)
        : (!ev_prev_q && ev_sync_q);
    assign sq_edge = !sq_prev_q && sq_sync_q;
    assign sub_mode = (POWER_MODE_I == utmr_pkg::PWR_SUBACTIVE)
        || (POWER_MODE_I == utmr_pkg::PWR_SUBSLEEP);

    always_comb
    begin
        src_tick = 1'b0;
        if (clk_sel == utmr_pkg::SRC_EVENT)
        begin
            src_tick = ev_edge;
        end
        else if (clk_sel == utmr_pkg::SRC_SUBQ)
        begin
            src_tick = sq_edge;
        end
        else
        begin
            src_tick = PRESCALE_TICK_I[clk_sel];
        end
    end

    always_comb
    begin
        run = 1'b0;
        case (POWER_MODE_I)
            utmr_pkg::PWR_ACTIVE, utmr_pkg::PWR_SLEEP: run = 1'b1;
            utmr_pkg::PWR_SUBACTIVE, utmr_pkg::PWR_SUBSLEEP:
                run = (clk_sel == utmr_pkg::SRC_EVENT) || (clk_sel == utmr_pkg::SRC_SUBQ);
            default: run = 1'b0;
        endcase
    end

    // Direction: field 00 up, 01 down, 1x from pin
    assign dir_down = mode_q[utmr_pkg::DIR_SRC_POS] ? dir_sync_q
        : mode_q[utmr_pkg::SOFT_DIR_POS];
    assign tick = run && src_tick;
    assign step = (sub_mode && aux_q[utmr_pkg::AUX_SUB8_POS] && (clk_sel == utmr_pkg::SRC_SUBQ))
        ? utmr_pkg::STEP_TWO : utmr_pkg::STEP_ONE;

    // Counter next value and wrap detection
    logic [8:0] sum;
    logic wrap;
    logic [7:0] count_d;

    assign sum = dir_down ? ({1'b0, count_q} - {1'b0, step}) : ({1'b0, count_q} + {1'b0, step});
    assign wrap = tick && sum[8];

    always_comb
    begin
        count_d = count_q;
        if (wr_reload)
        begin
            count_d = HWDATA_I[7:0];
        end
        else if (wrap && mode_q[utmr_pkg::RELOAD_SEL_POS])
        begin
            count_d = reload_q;
        end
        else if (tick)
        begin
            count_d = sum[7:0];
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= utmr_pkg::COUNT_RESET;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    // Aux register: flag (write 0 clears, set wins), enable, edge, eighth subclock
    always_ff @(posedge SYS_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aux_q <= utmr_pkg::AUX_RESET;
        end
        else
        begin
            if (wr_aux)
            begin
                aux_q[3:1] <= HWDATA_I[3:1];
            end
            if (wrap)
            begin
                aux_q[utmr_pkg::AUX_FLAG_POS] <= 1'b1;
            end
            else if (wr_aux && !HWDATA_I[utmr_pkg::AUX_FLAG_POS])
            begin
                aux_q[utmr_pkg::AUX_FLAG_POS] <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= aux_q[utmr_pkg::AUX_FLAG_POS] && aux_q[utmr_pkg::AUX_IEN_POS];
        end
    end

    assign HRDATA_O = rdata_q;
    assign HREADYOUT_O = ready_q;
    assign HRESP_O = 1'b0;
    assign IRQ_O = irq_q;
    assign COUNT_O = count_q;
endmodule

// *** verilog/utmr_pkg.sv ***
// Constants, types and register map of the 8-bit up/down reload timer.
// Assumes an AHB-Lite master with 32-bit data and word-only transfers.
package utmr_pkg;
    localparam logic [15:0] MODE_IDX = 16'hFFB4;
    localparam logic [15:0] COUNT_IDX = 16'hFFB5;
    localparam logic [15:0] AUX_IDX = 16'hFFB6;
    localparam logic [7:0] MODE_RESET = 8'h18;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] MODE_FIXED_ONES = 8'h18;
    localparam logic [7:0] MODE_WR_MASK = 8'hE7;
    localparam int RELOAD_SEL_POS = 7;
    localparam int DIR_SRC_POS = 6;
    localparam int SOFT_DIR_POS = 5;
    localparam int CLK_SEL_LSB = 0;
    localparam int AUX_FLAG_POS = 0;
    localparam int AUX_IEN_POS = 1;
    localparam int AUX_EDGE_POS = 2;
    localparam int AUX_SUB8_POS = 3;
    localparam logic [3:0] AUX_RESET = 4'h0;
    localparam logic [2:0] SRC_SUBQ = 3'h6;
    localparam logic [2:0] SRC_EVENT = 3'h7;
    localparam logic [7:0] STEP_ONE = 8'h01;
    localparam logic [7:0] STEP_TWO = 8'h02;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [5:0]
    {
        PWR_ACTIVE = 6'h01,
        PWR_SLEEP = 6'h02,
        PWR_WATCH = 6'h04,
        PWR_STANDBY = 6'h08,
        PWR_SUBACTIVE = 6'h10,
        PWR_SUBSLEEP = 6'h20
    } pwr_e;

    typedef struct packed
    {
        logic valid;
        logic write;
        logic [15:0] idx;
    } bus_req_s;
endpackage
